/* rtl/timer3_pkg.sv */
// Purpose: Shared constants for the 16-bit timer/counter and its Wishbone register file.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus; each register takes one word.
// Notes:   Register data sits in bits 7:0; the upper bits read as zero.
package timer3_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int        ADR_W          = 8;
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_WIDE_ACCESS   = 7;
  localparam int BIT_TIMEBASE_HI   = 6;
  localparam int BIT_PRESCALE_HI   = 5;
  localparam int BIT_PRESCALE_LO   = 4;
  localparam int BIT_TIMEBASE_LO   = 3;
  localparam int BIT_EXT_SYNC_N    = 2;
  localparam int BIT_CLOCK_SOURCE  = 1;
  localparam int BIT_COUNTER_RUN   = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int BIT_OVERFLOW  = 0;
  localparam int BIT_EXT_ARMED = 1;

  // ----------------------------------------------------------------
  // Counts and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
  localparam logic [1:0]  TB_SPLIT     = 2'h1;
  localparam logic [2:0]  PRESCALE_MASK_1 = 3'h0;
  localparam logic [2:0]  PRESCALE_MASK_2 = 3'h1;
  localparam logic [2:0]  PRESCALE_MASK_4 = 3'h3;
  localparam logic [2:0]  PRESCALE_MASK_8 = 3'h7;

endpackage

/* rtl/timer3_prescaler.sv */
// Purpose: Divides a one-cycle tick stream by 1, 2, 4 or 8.
// Assumes: Tick and clear are synchronous one-cycle pulses.
// Notes:   The output pulse lags the qualifying tick by one cycle.
`timescale 1ns/100ps
`default_nettype none
module timer3_prescaler (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [1:0] ratio_sel,
  output logic            pulse
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       pulse;
  } presc_state_t;

  presc_state_t st_q;
  presc_state_t st_d;
  logic [2:0]   mask;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.pulse = 1'b0;
    case (ratio_sel)
      2'h0:    mask = timer3_pkg::PRESCALE_MASK_1;
      2'h1:    mask = timer3_pkg::PRESCALE_MASK_2;
      2'h2:    mask = timer3_pkg::PRESCALE_MASK_4;
      default: mask = timer3_pkg::PRESCALE_MASK_8;
    endcase
    if (clear) begin
      st_d.cnt = 3'h0;
    end else if (tick) begin
      if ((st_q.cnt & mask) == mask) begin
        st_d.cnt = 3'h0;
        st_d.pulse = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = st_q.pulse;

endmodule
`default_nettype wire

/* rtl/timer3_ext_edge.sv */
// Purpose: Turns an external clock level into one-cycle rising-edge pulses.
// Assumes: The level may change at any time when the synchroniser is in use.
// Notes:   The first rising edge after enabling is skipped until a falling edge is seen.
`timescale 1ns/100ps
`default_nettype none
module timer3_ext_edge (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic ext_level,
  input  wire logic bypass,
  input  wire logic enable,
  output logic      rise_pulse,
  output logic      armed
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic armed;
    logic pulse;
  } edge_state_t;

  edge_state_t st_q;
  edge_state_t st_d;
  logic        level;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.sync1 = ext_level;
    st_d.sync2 = st_q.sync1;
    // Bypass saves two cycles of latency but trusts the level to be clean.
    level = bypass ? ext_level : st_q.sync2;
    st_d.prev = level;
    st_d.pulse = 1'b0;
    if (!enable) begin
      st_d.armed = 1'b0;
    end else if (st_q.prev && !level) begin
      st_d.armed = 1'b1;
    end
    if (enable && st_q.armed && !st_q.prev && level) begin
      st_d.pulse = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_pulse = st_q.pulse;
  assign armed      = st_q.armed;

endmodule
`default_nettype wire

/* rtl/timer3_counter.sv */
// Purpose: 16-bit timer/counter with prescaler, clock select and Wishbone registers.
// Assumes: core_clk is the oscillator; all inputs but the external clock level are synchronous to it.
// Notes:   Register accesses are answered one cycle after the request is seen.
//
// Behaviour
// - Count is 16 bits in two bytes, each readable and writable.
// - Rolling from maximum to zero sets the sticky overflow flag.
// - A trigger from a unit using this time base clears the count.
// - Control register is eight read/write bits, reset zero; bit 0 runs counter.
// - Bit 7 selects one 16-bit access instead of two 8-bit accesses.
// - Time-base pattern 1x gives both units this timer; 00 gives both companion.
// - Prescale 11 divides by 8, 10 by 4, 01 by 2.
// - External mode: bit 2 clear synchronises, set bypasses; internal ignores it.
// - Synchronisation is unavailable while system clock runs from a timer oscillator.
// - External edges are ignored until one falling edge follows enabling.
`timescale 1ns/100ps
`default_nettype none
module timer3_counter (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_clock_pin,
  input  wire logic        companion_osc_clk,
  input  wire logic        companion_osc_enable,
  input  wire logic        sysclk_from_timer_osc,
  input  wire logic        ccp1_trigger,
  input  wire logic        ccp2_trigger,
  output logic             ccp1_uses_this_timer,
  output logic             ccp2_uses_this_timer,
  output logic             overflow_flag,
  output logic      [15:0] count_value
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  control;
    logic [15:0] count;
    logic [7:0]  high_buf;
    logic        overflow;
    logic        ack;
    logic [7:0]  rdata;
    logic [1:0]  instr_div;
    logic        ccp1_tb;
    logic        ccp2_tb;
  } timer_state_t;

  timer_state_t st_q;
  timer_state_t st_d;

  logic       req;
  logic       wr_lane;
  logic       wide;
  logic       run;
  logic       ext_sel;
  logic       instr_tick;
  logic       ext_tick;
  logic       src_tick;
  logic       count_tick;
  logic       ext_armed;
  logic       ext_level;
  logic       sync_bypass;
  logic       presc_clr;
  logic       count_written;
  logic       ccp_clear;
  logic [1:0] tb_sel;

  // ----------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------
  assign wide    = st_q.control[timer3_pkg::BIT_WIDE_ACCESS];
  assign run     = st_q.control[timer3_pkg::BIT_COUNTER_RUN];
  assign ext_sel = st_q.control[timer3_pkg::BIT_CLOCK_SOURCE];
  assign tb_sel  = {st_q.control[timer3_pkg::BIT_TIMEBASE_HI],
                    st_q.control[timer3_pkg::BIT_TIMEBASE_LO]};

  // The companion oscillator, once enabled by its owner, replaces the pin.
  assign ext_level = companion_osc_enable ? companion_osc_clk : ext_clock_pin;

  // A synchroniser cannot work when the system clock itself is the timer
  // oscillator, so the path is forced into bypass then.
  assign sync_bypass = st_q.control[timer3_pkg::BIT_EXT_SYNC_N]
                     | sysclk_from_timer_osc;

  assign instr_tick = (st_q.instr_div == timer3_pkg::INSTR_DIV_LAST);
  assign src_tick   = run & (ext_sel ? ext_tick : instr_tick);

  timer3_ext_edge u_ext_edge (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .ext_level  (ext_level),
    .bypass     (sync_bypass),
    .enable     (run & ext_sel),
    .rise_pulse (ext_tick),
    .armed      (ext_armed)
  );

  timer3_prescaler u_prescaler (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .tick      (src_tick),
    .clear     (presc_clr),
    .ratio_sel ({st_q.control[timer3_pkg::BIT_PRESCALE_HI],
                 st_q.control[timer3_pkg::BIT_PRESCALE_LO]}),
    .pulse     (count_tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign req     = wb_cyc_i & wb_stb_i & ~st_q.ack;
  assign wr_lane = wb_we_i & wb_sel_i[0];

  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    presc_clr = 1'b0;
    count_written = 1'b0;
    st_d.instr_div = st_q.instr_div + 2'h1;

    // Time-base assignment for the two capture/compare units.
    st_d.ccp1_tb = tb_sel[1];
    st_d.ccp2_tb = tb_sel[1] | (tb_sel == timer3_pkg::TB_SPLIT);
    ccp_clear = (ccp1_trigger & st_q.ccp1_tb) | (ccp2_trigger & st_q.ccp2_tb);

    if (req) begin
      st_d.ack = 1'b1;
      st_d.rdata = 8'h00;
      case (wb_adr_i)
        timer3_pkg::OFS_CONTROL: begin
          st_d.rdata = st_q.control;
          if (wr_lane) begin
            st_d.control = wb_dat_i[7:0];
          end
        end
        timer3_pkg::OFS_COUNT_LOW: begin
          st_d.rdata = st_q.count[7:0];
          if (!wb_we_i && wide) begin
            st_d.high_buf = st_q.count[15:8];
          end
          if (wr_lane) begin
            presc_clr = 1'b1;
            count_written = 1'b1;
            if (wide) begin
              st_d.count = {st_q.high_buf, wb_dat_i[7:0]};
            end else begin
              st_d.count[7:0] = wb_dat_i[7:0];
            end
          end
        end
        timer3_pkg::OFS_COUNT_HIGH: begin
          st_d.rdata = wide ? st_q.high_buf : st_q.count[15:8];
          if (wr_lane) begin
            if (wide) begin
              st_d.high_buf = wb_dat_i[7:0];
            end else begin
              st_d.count[15:8] = wb_dat_i[7:0];
              presc_clr = 1'b1;
              count_written = 1'b1;
            end
          end
        end
        timer3_pkg::OFS_STATUS: begin
          st_d.rdata[timer3_pkg::BIT_OVERFLOW]  = st_q.overflow;
          st_d.rdata[timer3_pkg::BIT_EXT_ARMED] = ext_armed;
          if (wr_lane && wb_dat_i[timer3_pkg::BIT_OVERFLOW]) begin
            st_d.overflow = 1'b0;
          end
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end

    // A software write owns the count in its cycle; otherwise a trigger
    // clears it, and only without a trigger may the prescaled tick advance it.
    if (!count_written) begin
      if (ccp_clear) begin
        st_d.count = timer3_pkg::COUNT_RESET;
      end else if (count_tick) begin
        st_d.count = st_q.count + 16'h0001;
        if (st_q.count == timer3_pkg::COUNT_MAX) begin
          st_d.overflow = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.control <= timer3_pkg::CONTROL_RESET;
      st_q.count <= timer3_pkg::COUNT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o             = {24'h000000, st_q.rdata};
  assign wb_ack_o             = st_q.ack;
  assign ccp1_uses_this_timer = st_q.ccp1_tb;
  assign ccp2_uses_this_timer = st_q.ccp2_tb;
  assign overflow_flag        = st_q.overflow;
  assign count_value          = st_q.count;

endmodule
`default_nettype wire

/* verif/timer3_counter_chk.sv */
// Purpose: Port-level checks of the timer/counter.
// Assumes: One clock; reset_n is asynchronous and active low.
// Notes:   Count writes are excused from the step check, since they may load any value.
`timescale 1ns/100ps
`default_nettype none
module timer3_counter_chk (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ccp1_trigger,
  input wire logic        ccp2_trigger,
  input wire logic        ccp1_uses_this_timer,
  input wire logic        ccp2_uses_this_timer,
  input wire logic        overflow_flag,
  input wire logic [15:0] count_value
);
  logic take_wr;
  logic clr_req;
  assign take_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign clr_req = take_wr && wb_sel_i[0] && wb_dat_i[0] && wb_adr_i == timer3_pkg::OFS_STATUS;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wrap_seen;
    count_value == 16'hffff && !take_wr && !ccp1_trigger && !ccp2_trigger ##1
      count_value == 16'h0000;
  endsequence
  a_ack_next: assert property (bus_req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unit_order: assert property (ccp1_uses_this_timer |-> ccp2_uses_this_timer)
    else $error("unit one alone on this timer");
  a_trig_clear: assert property (((ccp1_trigger && ccp1_uses_this_timer) ||
    (ccp2_trigger && ccp2_uses_this_timer)) && !take_wr |=> count_value == 16'h0)
    else $error("trigger did not clear count");
  a_wrap_flag: assert property (wrap_seen |-> overflow_flag)
    else $error("wrap without overflow flag");
  a_flag_clear: assert property ($fell(overflow_flag) |-> $past(clr_req))
    else $error("overflow flag dropped by itself");
  a_step_one: assert property ($changed(count_value) && !$past(take_wr) |->
    count_value == $past(count_value) + 16'h1 || count_value == 16'h0)
    else $error("count moved by more than one");
endmodule
bind timer3_counter timer3_counter_chk u_chk (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ccp1_trigger,
  .ccp2_trigger, .ccp1_uses_this_timer, .ccp2_uses_this_timer, .overflow_flag, .count_value);
`default_nettype wire

/* verif/ccp_osc_model.sv */
// Purpose: Capture/compare units and companion oscillator beside the timer.
// Assumes: Bench commands are levels sampled on core_clk.
// Notes:   The oscillator stands still at zero while disabled.
`timescale 1ns/100ps
`default_nettype none
module ccp_osc_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic fire1,
  input  wire logic fire2,
  input  wire logic osc_on,
  output logic      ccp1_trigger,
  output logic      ccp2_trigger,
  output logic      companion_osc_clk,
  output logic      companion_osc_enable
);
  logic [2:0] div_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {div_q, ccp1_trigger, ccp2_trigger, companion_osc_clk, companion_osc_enable} <= 7'h0;
    end else begin
      div_q                <= div_q + 3'h1;
      ccp1_trigger         <= fire1;
      ccp2_trigger         <= fire2;
      companion_osc_enable <= osc_on;
      companion_osc_clk    <= osc_on && div_q[2];
    end
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the timer/counter.
// Assumes: The tick phase runs free, so periods are measured between two changes.
// Notes:   Run is kept off while count bytes are loaded so the model stays exact.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext_clock_pin;
  logic        sysclk_from_timer_osc, fire1, fire2, osc_on, ccp1_trigger, ccp2_trigger;
  logic        companion_osc_clk, companion_osc_enable, overflow_flag;
  logic        ccp1_uses_this_timer, ccp2_uses_this_timer;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, seed;
  logic [15:0] count_value, q;
  int          errors, tests_run, m_ctl, m_cnt, n;
  timer3_counter u_timer3_counter (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_clock_pin, .companion_osc_clk,
    .companion_osc_enable, .sysclk_from_timer_osc, .ccp1_trigger, .ccp2_trigger,
    .ccp1_uses_this_timer, .ccp2_uses_this_timer, .overflow_flag, .count_value);
  ccp_osc_model u_ccp_osc_model (.core_clk, .reset_n, .fire1, .fire2, .osc_on,
    .ccp1_trigger, .ccp2_trigger, .companion_osc_clk, .companion_osc_enable);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= sel_v;
    wb_dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 16);
    if (k >= 16) begin
      errors++;
      print_verdict();
    end
    q = {8'h0, wb_dat_o[7:0]};
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_change();
    logic [15:0] p;
    p = count_value;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (count_value === p && n < 64);
    if (n >= 64) begin
      errors++;
      print_verdict();
    end
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, ext_clock_pin, sysclk_from_timer_osc} = 5'h0;
    {fire1, fire2, osc_on, reset_n} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0f_00000000;
    sel_v = 4'hf;
    {errors, tests_run, seed} = {32'h0, 32'h0, 32'h62d6};
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(0, timer3_pkg::OFS_CONTROL, 8'h00);
    chk("control reset", 16'h0, q);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      m_ctl = int'(seed[7:0]);
      bus(1, timer3_pkg::OFS_CONTROL, 8'(m_ctl));
      bus(0, timer3_pkg::OFS_CONTROL, 8'h00);
      chk("control", 16'(m_ctl), q);
    end
    sel_v = 4'he;
    bus(1, timer3_pkg::OFS_CONTROL, ~8'(m_ctl));
    sel_v = 4'hf;
    bus(0, timer3_pkg::OFS_CONTROL, 8'h00);
    chk("masked write", 16'(m_ctl), q);
    bus(0, 8'h10, 8'h00);
    chk("unmapped", 16'h0, q);
    $display("test control done");
    for (int t = 0; t < 4; t++) begin
      bus(1, timer3_pkg::OFS_CONTROL, 8'((t & 2) * 32 + (t & 1) * 8));
      bus(1, timer3_pkg::OFS_COUNT_HIGH, 8'h00);
      chk("unit map", 16'({t[1], t[1] | t[0]}), {14'h0, ccp1_uses_this_timer,
        ccp2_uses_this_timer});
      for (int u = 1; u <= 2; u++) begin
        bus(1, timer3_pkg::OFS_COUNT_LOW, 8'h5a);
        fire1 <= (u == 1);
        fire2 <= (u == 2);
        @(posedge core_clk);
        {fire1, fire2} <= 2'h0;
        repeat (3) @(posedge core_clk);
        m_cnt = (t > 1 || (u == 2 && t == 1)) ? 0 : 'h5a;
        chk("trigger clear", 16'(m_cnt), count_value);
      end
    end
    $display("test time base done");
    seed = xs(seed);
    bus(1, timer3_pkg::OFS_CONTROL, 8'h00);
    bus(1, timer3_pkg::OFS_COUNT_LOW, seed[7:0]);
    bus(1, timer3_pkg::OFS_COUNT_HIGH, seed[15:8]);
    chk("count bytes", seed[15:0], count_value);
    m_cnt = int'(seed[15:0]);
    seed = xs(seed);
    bus(1, timer3_pkg::OFS_CONTROL, 8'h80);
    bus(1, timer3_pkg::OFS_COUNT_HIGH, seed[15:8]);
    chk("held high", 16'(m_cnt), count_value);
    bus(1, timer3_pkg::OFS_COUNT_LOW, seed[7:0]);
    chk("wide write", seed[15:0], count_value);
    bus(0, timer3_pkg::OFS_COUNT_LOW, 8'h00);
    chk("wide low", 16'(seed[7:0]), q);
    bus(0, timer3_pkg::OFS_COUNT_HIGH, 8'h00);
    chk("wide high", 16'(seed[15:8]), q);
    $display("test access done");
    for (int p = 0; p < 4; p++) begin
      bus(1, timer3_pkg::OFS_CONTROL, 8'(p * 16 + 1));
      wait_change();
      wait_change();
      chk("tick period", 16'(4 << p), 16'(n));
    end
    $display("test prescale done");
    bus(1, timer3_pkg::OFS_CONTROL, 8'h00);
    bus(1, timer3_pkg::OFS_COUNT_LOW, 8'hff);
    bus(1, timer3_pkg::OFS_COUNT_HIGH, 8'hff);
    bus(1, timer3_pkg::OFS_STATUS, 8'h01);
    bus(1, timer3_pkg::OFS_CONTROL, 8'h01);
    wait_change();
    chk("wrap", 16'h0, {15'h0, ~overflow_flag} | count_value);
    bus(0, timer3_pkg::OFS_STATUS, 8'h00);
    chk("status", 16'h1, q & 16'h1);
    bus(1, timer3_pkg::OFS_STATUS, 8'h01);
    bus(0, timer3_pkg::OFS_STATUS, 8'h00);
    chk("flag clear", 16'h0, q & 16'h1);
    $display("test overflow done");
    // Pass 0 synchronises, pass 1 bypasses by bit 2, pass 2 is forced into bypass.
    for (int b = 0; b < 3; b++) begin
      sysclk_from_timer_osc <= (b == 2);
      bus(1, timer3_pkg::OFS_CONTROL, 8'h00);
      bus(1, timer3_pkg::OFS_COUNT_LOW, 8'h00);
      bus(1, timer3_pkg::OFS_COUNT_HIGH, 8'h00);
      bus(1, timer3_pkg::OFS_CONTROL, 8'((b & 1) * 4 + 3));
      ext_clock_pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      ext_clock_pin <= 1'b0;
      repeat (8) @(posedge core_clk);
      bus(0, timer3_pkg::OFS_STATUS, 8'h00);
      chk("armed", 16'h2, q & 16'h2);
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("ext latency", (b == 0) ? 16'h0 : 16'h1, count_value);
      repeat (4) @(posedge core_clk);
      ext_clock_pin <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk("ext edges", 16'h1, count_value);
    end
    osc_on <= 1'b1;
    bus(1, timer3_pkg::OFS_CONTROL, 8'h07);
    repeat (100) @(posedge core_clk);
    chk("osc count", 16'h1, 16'(count_value > 16'h8));
    $display("test external done");
    reset_n <= 1'b0;
    @(posedge core_clk);
    chk("reset state", 16'h0, count_value | {15'h0, overflow_flag});
    reset_n <= 1'b1;
    bus(0, timer3_pkg::OFS_CONTROL, 8'h00);
    chk("control after reset", 16'h0, q);
    $display("test reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
